// File: rtl/ect_pkg.sv
/*
  Shared constants and types of the event counter block.
  Assumes a single 50 MHz system clock.
*/
package ect_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned PUB_PERIOD_S = 1;
  localparam int unsigned CHECK_PERIOD_MS = 200;
  localparam int unsigned PUB_CYCLES = CLK_HZ * PUB_PERIOD_S;
  localparam int unsigned CHECK_CYCLES = (CLK_HZ / 1000) * CHECK_PERIOD_MS;

  // ----------------------------------------------------------------
  // limits and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] TIME_LIMIT_S = 16'ha8c0;
  localparam logic [31:0] EVENT_LIMIT = 32'hee6b2800;
  localparam logic [31:0] THRESH_DEFAULT = 32'h00000064;
  localparam logic [15:0] PERIOD_DEFAULT_S = 16'h003c;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_THRESH = 8'h08;
  localparam logic [7:0] OFS_PERIOD = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_COUNT = 8'h14;
  localparam logic [7:0] OFS_TIME = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_TRIG_BIT = 2;
  localparam int unsigned CMD_TOGGLE_BIT = 0;
  localparam int unsigned CMD_DEFAULT_BIT = 1;
  localparam int unsigned STAT_RUN_BIT = 0;
  localparam int unsigned STAT_TRIG_BIT = 1;
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_STOP_BIT = 0;
  localparam int unsigned IRQ_AUTO_BIT = 1;
  localparam int unsigned IRQ_TICK_BIT = 2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ECT_FREE, ECT_TIME, ECT_EVENTS} ect_mode_t;
  typedef enum logic {ECT_IDLE, ECT_RUN} ect_state_t;

endpackage

// File: rtl/ect_tick_div.sv
/*
  Divider that gives a one-cycle enable pulse every CYCLES clocks.
  Assumes restart and run are synchronous to clk.
*/
module ect_tick_div #(
  parameter int unsigned CYCLES = ect_pkg::PUB_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic restart,
  input wire logic run,
  // pulse
  output logic tick
);

  localparam int unsigned W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  if (CYCLES < 1)
    $error("ect_tick_div: CYCLES must be at least one");

  logic [W-1:0] cnt;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt <= '0;
    else if (restart)
      cnt <= '0;
    else if (run)
    begin
      if (cnt == LAST)
        cnt <= '0;
      else
        cnt <= cnt + 1'b1;
    end
  end

  assign tick = run && !restart && (cnt == LAST);

endmodule

// File: rtl/ect_irq.sv
/*
  Sticky interrupt status with write-one-to-clear and a mask.
  Assumes set, clear and mask writes are synchronous to clk.
*/
module ect_irq #(
  parameter int unsigned W = ect_pkg::IRQ_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // events
  input wire logic [W-1:0] set,
  // software access
  input wire logic clr_we,
  input wire logic mask_we,
  input wire logic [W-1:0] wdata,
  // state and output
  output logic [W-1:0] status,
  output logic [W-1:0] mask,
  output logic irq
);

  if (W < 1)
    $error("ect_irq: W must be at least one");

  // set wins over a clear in the same cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      status <= '0;
    else
      status <= (status & ~(clr_we ? wdata : '0)) | set;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      mask <= '0;
    else if (mask_we)
      mask <= wdata;
  end

  assign irq = |(status & mask);

endmodule

// File: rtl/ect_counter.sv
/*
  Event counter with time base, three modes, automatic stop and a
  trigger output, reached over a plain register port.
  Assumes event_input_pin and bus strobes are synchronous to ref_clk.
*/
// Function
// [RQ1] count one per rising edge of the dedicated event input pin
// [RQ2] modes: free counting, events over a set time, time to n events
// [RQ3] threshold adjustable in event mode; default command loads 100
// [RQ4] threshold changes ignored outside event mode
// [RQ5] period in seconds adjustable only in time mode, default 60
// [RQ6] one command toggles run and stop; results stay readable after stop
// [RQ7] count and elapsed time published once a second while running
// [RQ8] elapsed time limited to 43200 s, events to four thousand million
// [RQ9] exceeding either limit stops counting without a command
// [RQ10] event limit and threshold compared every 200 ms
// [RQ11] enabled trigger output high for the whole counting interval
// [RQ12] time mode stops at the period, event mode at the threshold
module ect_counter #(
  parameter int unsigned PUB_CYCLES = ect_pkg::PUB_CYCLES,
  parameter int unsigned CHECK_CYCLES = ect_pkg::CHECK_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // event input
  input wire logic event_input_pin,
  // register port
  input wire logic [ect_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // outputs
  output logic trig_out,
  output logic irq
);

  if (PUB_CYCLES < 1 || CHECK_CYCLES < 1)
    $error("ect_counter: tick periods must be at least one cycle");

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ect_pkg::ect_state_t state;
  ect_pkg::ect_mode_t mode;
  logic trig_en, event_prev, running, edge_seen;
  logic [31:0] thresh, count, count_pub, next_count;
  logic [15:0] period, elapsed, time_pub, next_elapsed;
  logic [16:0] elapsed_inc;
  logic sec_tick, chk_tick, start, stop_cmd, stop;
  logic time_hit, evt_hit, auto_stop;
  logic [ect_pkg::IRQ_W-1:0] irq_set, irq_status, irq_mask;
  logic wr_ctrl, wr_cmd, wr_irq_stat, wr_irq_mask;

  assign running = (state == ect_pkg::ECT_RUN);

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  assign wr_ctrl = reg_wr && (reg_addr == ect_pkg::OFS_CTRL);
  assign wr_cmd = reg_wr && (reg_addr == ect_pkg::OFS_CMD);
  assign wr_irq_stat = reg_wr && (reg_addr == ect_pkg::OFS_IRQ_STAT);
  assign wr_irq_mask = reg_wr && (reg_addr == ect_pkg::OFS_IRQ_MASK);

  // ----------------------------------------------------------------
  // time bases
  // ----------------------------------------------------------------
  ect_tick_div #(.CYCLES(PUB_CYCLES)) u_sec_div (
    .clk(ref_clk), .rst(sys_rst), .restart(start), .run(running), .tick(sec_tick)
  );

  ect_tick_div #(.CYCLES(CHECK_CYCLES)) u_chk_div (
    .clk(ref_clk), .rst(sys_rst), .restart(start), .run(running), .tick(chk_tick)
  );

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  always_comb
  begin
    edge_seen = event_input_pin && !event_prev; // [RQ1]
    start = wr_cmd && reg_wdata[ect_pkg::CMD_TOGGLE_BIT] && !running; // [RQ6]
    stop_cmd = wr_cmd && reg_wdata[ect_pkg::CMD_TOGGLE_BIT] && running; // [RQ6]
    elapsed_inc = {1'b0, elapsed} + 17'h00001;
    // time limit and time mode period checked each second
    time_hit = sec_tick && ((elapsed_inc >= {1'b0, ect_pkg::TIME_LIMIT_S}) // [RQ9]
      || (mode == ect_pkg::ECT_TIME && elapsed_inc >= {1'b0, period})); // [RQ12]
    // event limit and threshold only compared on the slow check tick
    evt_hit = chk_tick && ((count > ect_pkg::EVENT_LIMIT) // [RQ10]
      || (mode == ect_pkg::ECT_EVENTS && count >= thresh)); // [RQ12]
    auto_stop = running && (time_hit || evt_hit); // [RQ9]
    stop = stop_cmd || auto_stop;
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      state <= ect_pkg::ECT_IDLE;
    else
    begin
      case (state)
        ect_pkg::ECT_IDLE:
          if (start)
            state <= ect_pkg::ECT_RUN;
        ect_pkg::ECT_RUN:
          if (stop)
            state <= ect_pkg::ECT_IDLE;
        default:
          state <= ect_pkg::ECT_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      event_prev <= 1'b0;
    else
      event_prev <= event_input_pin;
  end

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  always_comb
  begin
    next_count = count;
    next_elapsed = elapsed;
    if (start)
    begin
      next_count = '0;
      next_elapsed = '0;
    end
    else if (running)
    begin
      if (edge_seen && count != 32'hffffffff)
        next_count = count + 32'h00000001; // [RQ1]
      if (sec_tick && elapsed < ect_pkg::TIME_LIMIT_S)
        next_elapsed = elapsed_inc[15:0]; // [RQ8]
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      count <= '0;
      elapsed <= '0;
    end
    else
    begin
      count <= next_count;
      elapsed <= next_elapsed;
    end
  end

  // published values refresh each second and hold the result at stop
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      count_pub <= '0;
      time_pub <= '0;
    end
    else if (start)
    begin
      count_pub <= '0;
      time_pub <= '0;
    end
    else if (running && (sec_tick || stop))
    begin
      count_pub <= next_count; // [RQ7]
      time_pub <= next_elapsed; // [RQ6]
    end
  end

  // ----------------------------------------------------------------
  // settings
  // ----------------------------------------------------------------
  // mode and trigger enable only change while stopped
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mode <= ect_pkg::ECT_FREE;
      trig_en <= 1'b0;
    end
    else if (wr_ctrl && !running)
    begin
      case (reg_wdata[ect_pkg::CTRL_MODE_LSB +: 2]) // [RQ2]
        2'h1: mode <= ect_pkg::ECT_TIME;
        2'h2: mode <= ect_pkg::ECT_EVENTS;
        default: mode <= ect_pkg::ECT_FREE;
      endcase
      trig_en <= reg_wdata[ect_pkg::CTRL_TRIG_BIT];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      thresh <= ect_pkg::THRESH_DEFAULT;
    else if (mode == ect_pkg::ECT_EVENTS) // [RQ4]
    begin
      if (wr_cmd && reg_wdata[ect_pkg::CMD_DEFAULT_BIT])
        thresh <= ect_pkg::THRESH_DEFAULT; // [RQ3]
      else if (reg_wr && reg_addr == ect_pkg::OFS_THRESH)
        thresh <= reg_wdata; // [RQ3]
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      period <= ect_pkg::PERIOD_DEFAULT_S;
    else if (mode == ect_pkg::ECT_TIME) // [RQ5]
    begin
      if (wr_cmd && reg_wdata[ect_pkg::CMD_DEFAULT_BIT])
        period <= ect_pkg::PERIOD_DEFAULT_S; // [RQ5]
      else if (reg_wr && reg_addr == ect_pkg::OFS_PERIOD)
        period <= reg_wdata[15:0]; // [RQ5]
    end
  end

  // ----------------------------------------------------------------
  // trigger output
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      trig_out <= 1'b0;
    else if (start)
      trig_out <= trig_en; // [RQ11]
    else if (stop)
      trig_out <= 1'b0; // [RQ11]
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  always_comb
  begin
    irq_set = '0;
    irq_set[ect_pkg::IRQ_STOP_BIT] = running && stop;
    irq_set[ect_pkg::IRQ_AUTO_BIT] = auto_stop;
    irq_set[ect_pkg::IRQ_TICK_BIT] = running && sec_tick;
  end

  ect_irq #(
    .W(ect_pkg::IRQ_W)
  ) u_irq (
    .clk(ref_clk),
    .rst(sys_rst),
    .set(irq_set),
    .clr_we(wr_irq_stat),
    .mask_we(wr_irq_mask),
    .wdata(reg_wdata[ect_pkg::IRQ_W-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      reg_rdata <= '0;
    else if (!reg_rd)
      reg_rdata <= '0;
    else if (reg_addr == ect_pkg::OFS_CTRL)
      reg_rdata <= {29'h0, trig_en, mode};
    else if (reg_addr == ect_pkg::OFS_THRESH)
      reg_rdata <= thresh;
    else if (reg_addr == ect_pkg::OFS_PERIOD)
      reg_rdata <= {16'h0, period};
    else if (reg_addr == ect_pkg::OFS_STATUS)
      reg_rdata <= {30'h0, trig_out, running};
    else if (reg_addr == ect_pkg::OFS_COUNT)
      reg_rdata <= count_pub;
    else if (reg_addr == ect_pkg::OFS_TIME)
      reg_rdata <= {16'h0, time_pub};
    else if (reg_addr == ect_pkg::OFS_IRQ_STAT)
      reg_rdata <= {29'h0, irq_status};
    else if (reg_addr == ect_pkg::OFS_IRQ_MASK)
      reg_rdata <= {29'h0, irq_mask};
    else
      reg_rdata <= '0;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence start_seq;
    !running ##1 running;
  endsequence

  sequence stop_seq;
    running ##1 !running;
  endsequence

  edge_count_a: assert property ( // [RQ1]
    running && !start && event_input_pin && !$past(event_input_pin)
      && count != 32'hffffffff |=> count == $past(count) + 32'h00000001)
    else $error("rising edge not counted");

  start_clear_a: assert property ( // [RQ6]
    start_seq |-> count == 32'h0 && elapsed == 16'h0 && time_pub == 16'h0)
    else $error("start did not clear counters");

  stop_hold_a: assert property ( // [RQ6]
    stop_seq ##1 (!running && !start) |-> $stable(count_pub) && $stable(time_pub))
    else $error("result changed after stop");

  pub_update_a: assert property ( // [RQ7]
    running && sec_tick && !stop && elapsed < ect_pkg::TIME_LIMIT_S
      |=> time_pub == $past(elapsed) + 16'h0001 && count_pub == count)
    else $error("published values not refreshed on second");

  time_limit_a: assert property ( // [RQ8]
    elapsed <= ect_pkg::TIME_LIMIT_S)
    else $error("elapsed time beyond limit");

  limit_stop_a: assert property ( // [RQ9]
    running && chk_tick && count > ect_pkg::EVENT_LIMIT |=> !running)
    else $error("event limit did not stop counting");

  target_stop_a: assert property ( // [RQ12]
    running && chk_tick && mode == ect_pkg::ECT_EVENTS && count >= thresh
      |=> !running ##1 !running)
    else $error("threshold did not stop counting");

  thresh_lock_a: assert property ( // [RQ4]
    mode != ect_pkg::ECT_EVENTS |=> $stable(thresh))
    else $error("threshold changed outside event mode");

  thresh_default_a: assert property ( // [RQ3]
    mode == ect_pkg::ECT_EVENTS && wr_cmd && reg_wdata[ect_pkg::CMD_DEFAULT_BIT]
      |=> thresh == ect_pkg::THRESH_DEFAULT)
    else $error("default threshold not loaded");

  period_lock_a: assert property ( // [RQ5]
    mode != ect_pkg::ECT_TIME |=> $stable(period))
    else $error("period changed outside time mode");

  trig_span_a: assert property ( // [RQ11]
    trig_out |-> running && trig_en)
    else $error("trigger high while not counting");

  trig_fall_a: assert property ( // [RQ11]
    stop_seq |-> !trig_out)
    else $error("trigger did not fall at stop");

endmodule

// File: verif/ect_pulse_src.sv
/*
  Far-side model: event pulse source on the input pin and a watcher
  of the trigger output. Assumes one clock shared with the block.
*/
module ect_pulse_src (
  // clock
  input wire logic clk,
  // source control
  input wire logic en,
  input wire logic [3:0] gap,
  // pin side
  output logic pin,
  output int sent,
  // trigger watch
  input wire logic trig,
  output int trig_rises
);
  timeunit 1ns;
  timeprecision 1ps;

  int wait_c = 0;
  logic trig_q = 1'b0;

  initial
  begin
    pin = 1'b0;
    sent = 0;
    trig_rises = 0;
  end

  // ----------------------------------------------------------------
  // pulse source
  // ----------------------------------------------------------------
  // released source reads as the input stage pull-down level
  always @(posedge clk)
  begin
    if (!en)
    begin
      pin <= 1'b0;
      wait_c <= 0;
    end
    else if (pin)
    begin
      pin <= 1'b0;
      wait_c <= int'(gap) - 1;
    end
    else if (wait_c > 0)
      wait_c <= wait_c - 1;
    else
    begin
      pin <= 1'b1;
      sent <= sent + 1;
    end
  end

  // ----------------------------------------------------------------
  // trigger watcher
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    trig_q <= trig;
    if (trig === 1'b1 && trig_q === 1'b0)
      trig_rises <= trig_rises + 1;
  end
endmodule

// File: verif/tb.sv
/*
  Self-checking bench of the event counter.
  Assumes shortened second and check periods and the register map.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int PUB = 50;
  localparam int CHK = 10;

  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic trig_out;
  logic irq;
  logic event_input_pin;
  logic src_en = 1'b0;
  logic [3:0] src_gap = 4'h1;
  int sent;
  int trig_rises;
  int err_total = 0;
  int compares = 0;
  int seed = 82677;
  int n;
  int m;
  logic [31:0] d;
  logic [31:0] thr;
  logic [31:0] per;
  logic [7:0] ra [10] = '{ect_pkg::OFS_CTRL, ect_pkg::OFS_CMD, ect_pkg::OFS_THRESH,
    ect_pkg::OFS_PERIOD, ect_pkg::OFS_STATUS, ect_pkg::OFS_COUNT, ect_pkg::OFS_TIME,
    ect_pkg::OFS_IRQ_STAT, ect_pkg::OFS_IRQ_MASK, 8'h24};
  logic [31:0] rv [10] = '{32'h0, 32'h0, 32'h64, 32'h3c, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0};

  ect_counter #(.PUB_CYCLES(PUB), .CHECK_CYCLES(CHK)) dut_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .event_input_pin(event_input_pin),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .trig_out(trig_out), .irq(irq));

  ect_pulse_src src_u (.clk(ref_clk), .en(src_en), .gap(src_gap), .pin(event_input_pin),
    .sent(sent), .trig(trig_out), .trig_rises(trig_rises));

  initial
    forever #10 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] pick(input bit sel, input logic [31:0] old,
    input logic [31:0] nw);
    return sel ? nw : old;
  endfunction

  task automatic stop_test;
    $display("mismatches %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // read strobe one cycle, data taken while it stands in the next cycle
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string what);
    rd(a);
    chk(d, exp, what);
  endtask

  // counts cycles with trigger high, starting on a high sample
  task automatic high_len(input int lim, output int c);
    c = 1;
    while (trig_out === 1'b1 && c <= lim)
    begin
      @(negedge ref_clk);
      if (trig_out === 1'b1)
        c++;
    end
    if (c > lim)
    begin
      err_total++;
      $display("MISMATCH t=%0t trigger stuck high", $time);
      stop_test();
    end
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    $display("MISMATCH t=%0t run timed out", $time);
    stop_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    wr(8'h24, 32'hffffffff);
    for (n = 0; n < 10; n++)
      rc(ra[n], rv[n], "reset value");
    thr = ect_pkg::THRESH_DEFAULT;
    per = {16'h0, ect_pkg::PERIOD_DEFAULT_S};
    for (m = 0; m < 4; m++)
    begin
      d = $random(seed);
      wr(ect_pkg::OFS_CTRL, 32'(m));
      wr(ect_pkg::OFS_THRESH, d);
      wr(ect_pkg::OFS_PERIOD, d);
      thr = pick(m == 2, thr, d);
      per = pick(m == 1, per, {16'h0, d[15:0]});
      rc(ect_pkg::OFS_THRESH, thr, "threshold lock");
      rc(ect_pkg::OFS_PERIOD, per, "period lock");
      wr(ect_pkg::OFS_CMD, 32'h2);
      thr = pick(m == 2, thr, ect_pkg::THRESH_DEFAULT);
      per = pick(m == 1, per, {16'h0, ect_pkg::PERIOD_DEFAULT_S});
      rc(ect_pkg::OFS_THRESH, thr, "threshold default");
      rc(ect_pkg::OFS_PERIOD, per, "period default");
    end
    // free counting with trigger
    wr(ect_pkg::OFS_CTRL, 32'h4);
    src_gap <= 4'h1 + 4'($random(seed) & 3);
    wr(ect_pkg::OFS_CMD, 32'h1);
    src_en <= 1'b1;
    repeat (30) @(posedge ref_clk);
    src_en <= 1'b0;
    repeat (78) @(posedge ref_clk);
    wr(ect_pkg::OFS_CTRL, 32'h1);
    rc(ect_pkg::OFS_COUNT, 32'(sent), "published count");
    rc(ect_pkg::OFS_TIME, 32'h2, "published time");
    rc(ect_pkg::OFS_CTRL, 32'h4, "mode held while running");
    rc(ect_pkg::OFS_STATUS, 32'h3, "running with trigger");
    src_en <= 1'b1;
    repeat (10) @(posedge ref_clk);
    src_en <= 1'b0;
    repeat (2) @(posedge ref_clk);
    wr(ect_pkg::OFS_CMD, 32'h1);
    @(negedge ref_clk);
    chk({31'h0, trig_out}, 32'h0, "trigger after stop");
    chk(32'(trig_rises), 32'h1, "trigger rises");
    n = sent;
    src_en <= 1'b1;
    repeat (20) @(posedge ref_clk);
    src_en <= 1'b0;
    rc(ect_pkg::OFS_STATUS, 32'h0, "stopped");
    rc(ect_pkg::OFS_COUNT, 32'(n), "final count");
    rc(ect_pkg::OFS_TIME, 32'h2, "final time");
    rc(ect_pkg::OFS_IRQ_STAT, 32'h5, "stop and tick events");
    wr(ect_pkg::OFS_IRQ_MASK, 32'h2);
    wr(ect_pkg::OFS_IRQ_STAT, 32'h5);
    // time target
    per = 32'h1 + 32'($random(seed) & 3);
    wr(ect_pkg::OFS_CTRL, 32'h5);
    wr(ect_pkg::OFS_PERIOD, per);
    wr(ect_pkg::OFS_CMD, 32'h1);
    @(negedge ref_clk);
    chk({31'h0, trig_out}, 32'h1, "trigger at start");
    high_len(400, n);
    chk(32'(n >= per * PUB && n <= per * PUB + 1), 32'h1, "time run length");
    rc(ect_pkg::OFS_TIME, per, "time at target");
    rc(ect_pkg::OFS_IRQ_STAT, 32'h7, "auto stop event");
    chk({31'h0, irq}, 32'h1, "unmasked interrupt");
    wr(ect_pkg::OFS_IRQ_STAT, 32'h7);
    @(negedge ref_clk);
    chk({31'h0, irq}, 32'h0, "interrupt cleared");
    // event target
    thr = 32'h3 + 32'($random(seed) & 7);
    wr(ect_pkg::OFS_CTRL, 32'h2);
    wr(ect_pkg::OFS_THRESH, thr);
    src_gap <= 4'h1;
    wr(ect_pkg::OFS_CMD, 32'h1);
    src_en <= 1'b1;
    d = 32'h1;
    for (m = 0; m < 200 && d[0] !== 1'b0; m++)
      rd(ect_pkg::OFS_STATUS);
    src_en <= 1'b0;
    chk({31'h0, d[0]}, 32'h0, "event target stop");
    rd(ect_pkg::OFS_COUNT);
    chk(32'(d >= thr && d <= thr + CHK / 2), 32'h1, "count overshoot");
    rc(ect_pkg::OFS_IRQ_STAT, 32'h3, "event auto stop flags");
    chk({31'h0, irq}, 32'h1, "auto stop interrupt");
    chk(32'(trig_rises), 32'h2, "trigger off when disabled");
    stop_test();
  end
endmodule
